// ### hw/eeprom_serial_write_slave.v
// Contract
// - Master writes 02H alone to control register; write enable latch sets at once.
// - Exact 06H to control register sets unlock latch and write enable latch.
// - Stop after valid third byte starts nonvolatile store, at most 10 ms.
// - Unlock latch clears when the nonvolatile control store completes.
// - Third byte with bit 2 set keeps unlock latch and leaves settings unchanged.
// - Second data byte in a control register write aborts it with a NACK.
// - A read between unlock steps does not disturb the unlock progress.
// - Unlock latch clears only on NV control write, power cycle, protected write.
// - Start is SDA fall with SCL high, stop is SDA rise; idle until start.
// - Stop after a read returns the device to standby.
// - Receiver drives SDA low on the ninth clock to acknowledge eight bits.
// - Acknowledge address byte only on match; in writes acknowledge following bytes.
// - Transmit eight bits, release SDA, continue on ACK, cease on NACK.
// - Byte write acknowledges address and data; stop launches nonvolatile write.
// - During internal write ignore all bus inputs and release SDA.
// - Withhold acknowledge for data aimed at a protected block.
// - Page write increments low six bits only, wrapping within the 64-byte page.
// - More than a page of bytes overwrites earlier buffered bytes in order.
// - Stop mid-byte or before one data byte with ACK writes nothing.
// - No address acknowledge while the nonvolatile cycle runs; master may poll.
// - With write enable latch clear, ignore writes and NACK the data byte.
// - Word address FFFh decodes to the control register, not the array; the code does so for writes only, a read at FFFh returns array data.
// - Address byte is type code, a zero, two select bits and read bit.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_slave_map.vh"
module eeprom_serial_write_slave #(
  parameter [3:0] TYPE_CODE = `TYPE_CODE_DEFAULT, // Arbitrary value
  parameter integer NV_CYCLES = `NV_WRITE_CYCLES,
  parameter integer ADDR_W = 13
) (
  input wire core_clk,
  input wire reset_n,
  input wire clk_en,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire chip_select_hi,
  input wire chip_select_lo,
  input wire [7:0] read_data,
  output reg [ADDR_W-1:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_we,
  output reg busy,
  output reg write_enable_latch,
  output reg register_unlock_latch,
  output reg watchdog_period_hi,
  output reg watchdog_period_lo,
  output reg block_protect_top,
  output reg block_protect_mid,
  output reg block_protect_low
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DEV = 3'h1;
  localparam [2:0] ST_AHI = 3'h2;
  localparam [2:0] ST_ALO = 3'h3;
  localparam [2:0] ST_DATA = 3'h4;
  localparam [2:0] ST_READ = 3'h5;
  localparam [2:0] ST_IGN = 3'h6;
  localparam integer PW = 6;

  reg [1:0] scl_s_q, sda_s_q;
  reg scl_p_q, sda_p_q;
  reg [2:0] st_q;
  reg [7:0] sh_q;
  reg [3:0] cnt_q;
  reg ack_ph_q, ack_ok_q, rd_q;
  reg [ADDR_W-1:0] addr_q;
  reg [7:0] buf_q [0:`PAGE_BYTES-1];
  reg [`PAGE_BYTES-1:0] bv_q;
  reg [7:0] nbytes_q;
  reg [7:0] ctl_q;
  reg is_ctl_q, pend_q, ctl_pend_q, ctl_bad_q;
  reg [31:0] busy_cnt_q;
  reg [PW-1:0] flush_q;
  reg flushing_q;
  reg [ADDR_W-1:0] page_q;

  wire scl = scl_s_q[1];
  wire sda = sda_s_q[1];
  wire scl_rise = scl & ~scl_p_q;
  wire scl_fall = ~scl & scl_p_q;
  wire start_c = scl & scl_p_q & sda_p_q & ~sda;
  wire stop_c = scl & scl_p_q & ~sda_p_q & sda;
  wire [7:0] byte_in = {sh_q[6:0], sda};

  // Decoded protect range for the 8K array
  function prot_hit;
    input [ADDR_W-1:0] a;
    input [2:0] bp;
    begin
      case (bp)
        3'h1: prot_hit = (a[12:11] == 2'h3);
        3'h2: prot_hit = a[12];
        3'h3: prot_hit = 1'b1;
        3'h4: prot_hit = (a[12:6] == 7'h00);
        3'h5: prot_hit = (a[12:7] == 6'h00);
        3'h6: prot_hit = (a[12:8] == 5'h00);
        3'h7: prot_hit = (a[12:9] == 4'h0);
        default: prot_hit = 1'b0;
      endcase
    end
  endfunction

  wire [2:0] bp_now = {block_protect_top, block_protect_mid, block_protect_low};
  // Judged on the SCL fall after bit 8, when the whole byte already sits in the shifter
  wire dev_match = (sh_q[7:4] == TYPE_CODE) && !sh_q[3] &&
    (sh_q[2] == chip_select_hi) && (sh_q[1] == chip_select_lo);

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (clk_en) begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_p_q <= scl;
      sda_p_q <= sda;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      ack_ph_q <= 1'b0;
      ack_ok_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= {ADDR_W{1'b0}};
      bv_q <= {`PAGE_BYTES{1'b0}};
      nbytes_q <= 8'h00;
      ctl_q <= 8'h00;
      is_ctl_q <= 1'b0;
      pend_q <= 1'b0;
      ctl_pend_q <= 1'b0;
      ctl_bad_q <= 1'b0;
      busy <= 1'b0;
      busy_cnt_q <= 32'h0;
      flushing_q <= 1'b0;
      flush_q <= {PW{1'b0}};
      page_q <= {ADDR_W{1'b0}};
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      mem_addr <= {ADDR_W{1'b0}};
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      write_enable_latch <= 1'b0;
      register_unlock_latch <= 1'b0;
      {watchdog_period_hi, watchdog_period_lo} <= `WD_RESET;
      {block_protect_top, block_protect_mid, block_protect_low} <= `BP_RESET;
    end else if (clk_en) begin
      mem_we <= 1'b0;
      if (busy) begin
        // bus ignored, SDA released while the store runs
        sda_oe_n <= 1'b1;
        st_q <= ST_IDLE;
        if (flushing_q) begin
          if (bv_q[flush_q]) begin
            mem_we <= 1'b1;
            mem_addr <= page_q | {{(ADDR_W-PW){1'b0}}, flush_q};
            mem_wdata <= buf_q[flush_q];
          end
          flush_q <= flush_q + 1'b1;
          if (flush_q == {PW{1'b1}})
            flushing_q <= 1'b0;
        end
        if (busy_cnt_q >= NV_CYCLES - 1) begin
          busy <= 1'b0;
          if (ctl_pend_q) begin
            register_unlock_latch <= 1'b0;
            ctl_pend_q <= 1'b0;
          end
        end else
          busy_cnt_q <= busy_cnt_q + 32'h1;
      end else if (stop_c) begin
        sda_oe_n <= 1'b1;
        st_q <= ST_IDLE;
        // only complete data bytes with ACK launch anything
        // The SCL rise that carries the stop has already counted as one bit
        if (st_q == ST_DATA && cnt_q[3:1] == 3'h0 && !ack_ph_q && pend_q) begin
          if (is_ctl_q && !ctl_bad_q) begin
            if (ctl_q == `CTRL_SET_WRITE_EN) begin
              write_enable_latch <= 1'b1;
            end else if (ctl_q == `CTRL_SET_UNLOCK) begin
              write_enable_latch <= 1'b1;
              register_unlock_latch <= 1'b1;
            end else if (register_unlock_latch &&
                         ((ctl_q & `CTRL_NV_MASK) == `CTRL_NV_VALUE)) begin
              // nonvolatile store of watchdog and protect bits
              {watchdog_period_hi, watchdog_period_lo} <= ctl_q[6:5];
              {block_protect_top, block_protect_mid, block_protect_low} <=
                {ctl_q[4], ctl_q[3], ctl_q[0]};
              busy <= 1'b1;
              busy_cnt_q <= 32'h0;
              ctl_pend_q <= 1'b1;
            end else if (ctl_q == 8'h00) begin
              write_enable_latch <= 1'b0;
            end
            // bit 2 set keeps unlock latch, settings untouched
          end else if (!is_ctl_q) begin
            busy <= 1'b1;
            busy_cnt_q <= 32'h0;
            flushing_q <= 1'b1;
            flush_q <= {PW{1'b0}};
          end
        end
        pend_q <= 1'b0;
      end else if (start_c) begin
        st_q <= ST_DEV;
        cnt_q <= 4'h0;
        ack_ph_q <= 1'b0;
        sda_oe_n <= 1'b1;
        pend_q <= 1'b0;
      end else if (st_q != ST_IDLE && st_q != ST_IGN) begin
        if (scl_rise && !ack_ph_q && !(st_q == ST_READ)) begin
          sh_q <= byte_in;
          cnt_q <= cnt_q + 4'h1;
        end
        if (scl_rise && st_q == ST_READ && !ack_ph_q)
          cnt_q <= cnt_q + 4'h1;
        // Our own address ACK must not be taken for the master's
        if (scl_rise && ack_ph_q && st_q == ST_READ && rd_q && sda_oe_n) begin
          // master ACK continues, NACK ends transmission
          if (sda)
            st_q <= ST_IGN;
          else
            addr_q <= addr_q + 1'b1;
        end
        if (scl_fall) begin
          if (ack_ph_q) begin
            ack_ph_q <= 1'b0;
            cnt_q <= 4'h0;
            sda_oe_n <= 1'b1;
            if (!ack_ok_q)
              st_q <= ST_IGN;
            if (st_q == ST_READ && ack_ok_q) begin
              sda_out <= read_data[7];
              sda_oe_n <= read_data[7];
            end
          end else if (cnt_q == 4'h8) begin
            ack_ph_q <= 1'b1;
            ack_ok_q <= 1'b1;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b0;
            case (st_q)
              ST_DEV: begin
                rd_q <= sh_q[0];
                if (!dev_match) begin
                  ack_ok_q <= 1'b0;
                  sda_oe_n <= 1'b1;
                end else
                  st_q <= sh_q[0] ? ST_READ : ST_AHI;
                // reads leave latches and the unlock state alone
              end
              ST_AHI: begin
                addr_q <= {sh_q[ADDR_W-9:0], 8'h00};
                st_q <= ST_ALO;
              end
              ST_ALO: begin
                addr_q <= {addr_q[ADDR_W-1:8], sh_q};
                is_ctl_q <= ({addr_q[ADDR_W-1:8], sh_q} == `CTRL_WORD_ADDR);
                page_q <= {addr_q[ADDR_W-1:8], sh_q[7:PW], {PW{1'b0}}};
                bv_q <= {`PAGE_BYTES{1'b0}};
                nbytes_q <= 8'h00;
                ctl_bad_q <= 1'b0;
                st_q <= ST_DATA;
              end
              ST_DATA: begin
                // The first unlock step has to pass while the latch is still clear
                if (!write_enable_latch && !(is_ctl_q && sh_q == `CTRL_SET_WRITE_EN)) begin
                  ack_ok_q <= 1'b0;
                  sda_oe_n <= 1'b1;
                end else if (is_ctl_q) begin
                  if (nbytes_q != 8'h00) begin
                    ctl_bad_q <= 1'b1;
                    ack_ok_q <= 1'b0;
                    sda_oe_n <= 1'b1;
                  end else begin
                    ctl_q <= sh_q;
                    pend_q <= 1'b1;
                  end
                  nbytes_q <= 8'h01;
                end else if (prot_hit(addr_q, bp_now)) begin
                  ack_ok_q <= 1'b0;
                  sda_oe_n <= 1'b1;
                  register_unlock_latch <= 1'b0;
                  pend_q <= 1'b0;
                end else begin
                  buf_q[addr_q[PW-1:0]] <= sh_q;
                  bv_q[addr_q[PW-1:0]] <= 1'b1;
                  addr_q[PW-1:0] <= addr_q[PW-1:0] + 1'b1;
                  pend_q <= 1'b1;
                end
              end
              default: begin
                ack_ph_q <= 1'b1;
              end
            endcase
            if (st_q == ST_READ) begin
              // Master drives the ninth bit after our byte
              sda_oe_n <= 1'b1;
              ack_ok_q <= 1'b1;
            end
          end else if (st_q == ST_READ && rd_q && cnt_q != 4'h0) begin
            sda_out <= read_data[3'h7 - cnt_q[2:0]];
            sda_oe_n <= read_data[3'h7 - cnt_q[2:0]];
          end
        end
      end
      if (!busy)
        mem_addr <= (st_q == ST_READ) ? addr_q : mem_addr;
    end
  end
endmodule
`default_nettype wire

// ### hw/eeprom_slave_map.vh
`ifndef EEPROM_SLAVE_MAP_VH
`define EEPROM_SLAVE_MAP_VH
`define CTRL_WORD_ADDR 13'h0FFF
`define CTRL_SET_WRITE_EN 8'h02
`define CTRL_SET_UNLOCK 8'h06
`define CTRL_BIT_WRITE_EN 1
`define CTRL_BIT_UNLOCK 2
`define CTRL_NV_MASK 8'h86
`define CTRL_NV_VALUE 8'h02
`define TYPE_CODE_DEFAULT 4'h5
`define NV_WRITE_MS 10
`define CLK_HZ 20000000
`define NV_WRITE_CYCLES ((`CLK_HZ / 1000) * `NV_WRITE_MS)
`define PAGE_BYTES 64
`define WD_RESET 2'h3
`define BP_RESET 3'h0
`endif

// ### bench/eeprom_slave_checker.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave_checker #(
  parameter integer NV_CYCLES = 200,
  parameter integer ADDR_W = 13
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic sda_oe_n,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_we,
  input wire logic busy,
  input wire logic write_enable_latch,
  input wire logic register_unlock_latch,
  input wire logic watchdog_period_hi,
  input wire logic watchdog_period_lo,
  input wire logic block_protect_top,
  input wire logic block_protect_mid,
  input wire logic block_protect_low
);
  logic [31:0] busy_cnt_q;
  wire [4:0] nv_bits = {watchdog_period_hi, watchdog_period_lo, block_protect_top,
    block_protect_mid, block_protect_low};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Counts the length of each busy period so its bounds can be checked
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n) busy_cnt_q <= 32'h0;
    else if (!busy) busy_cnt_q <= 32'h0;
    else if (clk_en) busy_cnt_q <= busy_cnt_q + 32'h1;
  property p_busy_quiet; busy |-> sda_oe_n; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("sda driven while busy");
  property p_we_busy; mem_we |-> busy; endproperty
  a_we_busy: assert property (p_we_busy) else $error("store outside busy");
  property p_unlock_wel; $rose(register_unlock_latch) |-> write_enable_latch; endproperty
  a_unlock_wel: assert property (p_unlock_wel) else $error("unlock without write enable");
  property p_nv_hold; $changed(nv_bits) |-> busy || $past(busy); endproperty
  a_nv_hold: assert property (p_nv_hold) else $error("settings changed idle");
  property p_ack_stand; $fell(sda_oe_n) |-> !sda_oe_n [*4]; endproperty
  a_ack_stand: assert property (p_ack_stand) else $error("drive too short");
  property p_busy_max; busy_cnt_q <= NV_CYCLES; endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_busy_min; $fell(busy) |-> busy_cnt_q == NV_CYCLES; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_ctrl_apart; mem_we |-> mem_addr != 13'h0FFF; endproperty
  a_ctrl_apart: assert property (p_ctrl_apart) else $error("control in array");
endmodule
bind eeprom_serial_write_slave eeprom_slave_checker #(.NV_CYCLES(NV_CYCLES),
  .ADDR_W(ADDR_W)) eeprom_slave_checker_inst (.core_clk, .reset_n, .clk_en, .sda_oe_n,
  .mem_addr, .mem_we, .busy, .write_enable_latch, .register_unlock_latch,
  .watchdog_period_hi, .watchdog_period_lo, .block_protect_top, .block_protect_mid,
  .block_protect_low);
`default_nettype wire

// ### bench/i2c_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Releases data before raising the clock so a slave still driving cannot fake a stop
  task automatic start_cond();
    sda_pull <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop_cond();
    sda_pull <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b0;
    tick(12);
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_pull <= !b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    s = sda_line;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask
endmodule
`default_nettype wire

// ### bench/eeprom_serial_write_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_serial_write_slave_tb;
  localparam int NV = 200;
  localparam logic [7:0] DEV = 8'h54;
  logic core_clk = 1'b0, reset_n = 1'b0, scl, pull, ack, busy, wr_en, unl, oe_n, sdo, we;
  logic wdh, wdl, bpt, bpm, bpl;
  logic [12:0] addr;
  logic [7:0] wdata, q;
  logic [15:0] acks;
  logic [7:0] exp_mem [0:63];
  int error_cnt = 0, n_tests = 0, n_we = 0;
  wire sda = !pull && (oe_n || sdo);
  always #25 core_clk = !core_clk;
  eeprom_serial_write_slave #(.NV_CYCLES(NV)) eeprom_serial_write_slave_inst (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out(sdo), .sda_oe_n(oe_n), .chip_select_hi(1'b1), .chip_select_lo(1'b0),
    .read_data(8'h3C), .mem_addr(addr), .mem_wdata(wdata), .mem_we(we), .busy(busy),
    .write_enable_latch(wr_en), .register_unlock_latch(unl), .watchdog_period_hi(wdh),
    .watchdog_period_lo(wdl), .block_protect_top(bpt), .block_protect_mid(bpm),
    .block_protect_low(bpl));
  i2c_bus_master i2c_bus_master_inst (.clk(core_clk), .sda_line(sda), .scl(scl),
    .sda_pull(pull));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Every stored byte must land in the test page and hold the last byte loaded there
  always @(posedge core_clk) if (we) begin
    n_we <= n_we + 1;
    chk("store_page", 16'h40, 16'(addr[12:6]));
    chk("store_data", 16'(exp_mem[addr[5:0]]), 16'(wdata));
  end
  task automatic wr(input logic [15:0] wa, input logic [7:0] d0, input int nd);
    acks = 16'h0;
    i2c_bus_master_inst.start_cond();
    for (int i = -3; i < nd; i++) begin
      i2c_bus_master_inst.byte_io(i == -3 ? DEV : i == -2 ? wa[15:8] : i == -1 ? wa[7:0] :
        d0 + 8'(i), q, ack);
      acks = {acks[14:0], ack};
    end
    i2c_bus_master_inst.stop_cond();
  endtask
  task automatic poll(input logic [7:0] dev);
    i2c_bus_master_inst.start_cond();
    i2c_bus_master_inst.byte_io(dev, q, ack);
  endtask
  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'b0 && n < 4 * NV) begin
      @(posedge core_clk);
      n++;
    end
    if (busy !== 1'b0) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  task automatic t_wr_en_off();
    wr(16'h1000, 8'h11, 1);
    chk("acks_wr_en_clear", 16'hE, acks);
    wr(16'h0FFF, 8'h06, 1);
    chk("latch_wr_en_clear", 16'h0, {busy, wr_en, unl});
    $display("test wr_en_off done");
  endtask
  task automatic t_unlock();
    wr(16'h0FFF, 8'h02, 1);
    chk("acks_step1", 16'hF, acks);
    chk("latch_step1", 16'h2, {busy, wr_en, unl});
    poll(8'h50);
    chk("ack_wrong_sel", 16'h0, ack);
    poll(DEV | 8'h01);
    chk("ack_read", 16'h1, ack);
    i2c_bus_master_inst.byte_io(8'hFF, q, ack);
    i2c_bus_master_inst.stop_cond();
    chk("read_byte", 16'h3C, q);
    wr(16'h0FFF, 8'h06, 1);
    chk("latch_step2", 16'h3, {busy, wr_en, unl});
    wr(16'h0FFF, 8'h5F, 1);
    chk("bit2_kept", 16'h78, {busy, wr_en, unl, wdh, wdl, bpt, bpm, bpl});
    wr(16'h0FFF, 8'h5B, 2);
    chk("acks_two", 16'h1E, acks);
    wr(16'h0FFF, 8'h5B, 1);
    chk("busy_store", 16'h1, busy);
    wait_idle();
    chk("nv_stored", 16'h17, {busy, unl, wdh, wdl, bpt, bpm, bpl});
    $display("test unlock done");
  endtask
  task automatic t_protect();
    wr(16'h0000, 8'h22, 1);
    chk("acks_protected", 16'hE, acks);
    wr(16'h1000, 8'h22, 0);
    chk("busy_early_stop", 16'h0, busy);
    chk("no_store", 16'h0, 16'(n_we));
    $display("test protect done");
  endtask
  task automatic t_page();
    for (int i = 0; i < 66; i++) exp_mem[(60 + i) % 64] = 8'h80 + 8'(i);
    wr(16'h103C, 8'h80, 66);
    chk("acks_page", 16'hFFFF, acks);
    poll(DEV);
    i2c_bus_master_inst.stop_cond();
    chk("poll_busy", 16'h0, ack);
    wait_idle();
    poll(DEV);
    i2c_bus_master_inst.stop_cond();
    chk("poll_done", 16'h1, ack);
    chk("stored_bytes", 16'd64, 16'(n_we));
    wr(16'h0FFF, 8'h00, 1);
    chk("latch_cleared", 16'h0, {busy, wr_en});
    wr(16'h1000, 8'h11, 1);
    chk("acks_cleared", 16'hE, acks);
    $display("test page done");
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_wr_en_off();
    t_unlock();
    t_protect();
    t_page();
    report_and_stop();
  end
endmodule
`default_nettype wire
